// [src/acc_map.svh]
// Register offsets, field positions and reset values of the comparator block.
// Assumes inclusion from the top module and the testbench only.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_OFF_CSR        4'h0
`define ACC_OFF_CSRB       4'h4
`define ACC_OFF_ISTAT      4'h8
`define ACC_OFF_IMASK      4'hc
`define ACC_CSR_MODE_LO    0
`define ACC_CSR_MODE_HI    1
`define ACC_CSR_CAPT       2
`define ACC_CSR_IEN        3
`define ACC_CSR_FLAG       4
`define ACC_CSR_RESULT     5
`define ACC_CSR_BANDGAP    6
`define ACC_CSR_POWER_OFF  7
`define ACC_CSRB_MUX_EN    6
`define ACC_IST_EDGE       0
`define ACC_IST_RISE       1
`define ACC_IST_FALL       2
`define ACC_CSR_RESET      8'h00
`define ACC_CSRB_RESET     8'h00
`define ACC_IMASK_RESET    8'h00
`define ACC_RESP_OKAY      2'h0
`define ACC_RESP_SLVERR    2'h2
`endif

// [src/acc_pkg.sv]
// Types shared by the comparator control block.
// Assumes acc_map.svh is on the include path.
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL     = 2'h2,
    ACC_MODE_RISE     = 2'h3
  } acc_mode_t;

  typedef enum logic [1:0] {
    ACC_W_IDLE = 2'h0,
    ACC_W_RESP = 2'h1
  } acc_wstate_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] data;
  } acc_rd_t;

  typedef struct packed {
    logic        power_off;
    logic        bandgap;
    logic        capt;
    logic        ien;
    acc_mode_t   mode;
  } acc_ctrl_t;
endpackage

// [src/acc_sync.sv]
// Two flip-flop synchroniser for the raw comparator output.
// Assumes an asynchronous input and CLOCK/RST of the top.
module acc_sync
  import acc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } acc_sync_t;

  acc_sync_t st;
  acc_sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// [src/acc_top.sv]
// Analog comparator control: input selection, power-down, edge interrupt,
// capture routing and an AXI4-Lite register slave.
// Assumes the analog comparator sits outside; its raw output is async.
`include "acc_map.svh"

module acc_top
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // AXI4-Lite write channels
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read channels
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Analog side
  input  wire logic        CMP_RAW,
  input  wire logic        CONVERTER_ENABLE,
  output logic             CMP_POWER_OFF,
  output logic             CMP_POS_USE_BANDGAP,
  output logic             CMP_NEG_USE_MUX,
  // Core interrupt and timer
  input  wire logic        GLOBAL_IRQ_ENABLE,
  input  wire logic        IRQ_VECTOR_TAKEN,
  output logic             CMP_IRQ,
  output logic             CAPTURE_TRIGGER,
  output logic             IRQ
);
  typedef struct packed {
    acc_ctrl_t   ctrl;
    logic        mux_en;
    logic        flag;
    logic        result_q;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic [3:0]  awaddr;
    logic        aw_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_have;
    acc_wstate_t wstate;
    logic [1:0]  bresp;
    logic        rvalid;
    acc_rd_t     rd;
    logic [1:0]  rresp;
  } acc_state_t;

  acc_state_t st;
  acc_state_t next_st;
  logic       cmp_result;
  logic       conv_en;
  logic       gie;

  // Result bit is the synchronised comparator output
  acc_sync u_sync (
    .clk (CLOCK),
    .rst (RST),
    .d   (CMP_RAW),
    .q   (cmp_result)
  );

  // Converter enable and global enable are same-clock core signals
  assign conv_en = CONVERTER_ENABLE;
  assign gie     = GLOBAL_IRQ_ENABLE;

  function automatic logic mode_hit(input acc_mode_t m, input logic rise,
                                    input logic fall);
    case (m)
      ACC_MODE_TOGGLE: mode_hit = rise | fall;
      ACC_MODE_FALL:   mode_hit = fall;
      ACC_MODE_RISE:   mode_hit = rise;
      default:         mode_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic       en);
    merge = en ? nw : old;
  endfunction

  logic       rise;
  logic       fall;
  logic       edge_hit;
  logic       do_write;
  logic [7:0] wbyte;
  logic [7:0] csr_rd;

  assign rise     = cmp_result & ~st.result_q;
  assign fall     = ~cmp_result & st.result_q;
  assign edge_hit = mode_hit(st.ctrl.mode, rise, fall);
  assign do_write = st.aw_have && st.w_have && st.wstate == ACC_W_IDLE;
  assign wbyte    = st.wdata[7:0];

  always_comb begin
    csr_rd = 8'h00;
    csr_rd[`ACC_CSR_POWER_OFF] = st.ctrl.power_off;
    csr_rd[`ACC_CSR_BANDGAP]   = st.ctrl.bandgap;
    csr_rd[`ACC_CSR_RESULT]    = cmp_result;
    csr_rd[`ACC_CSR_FLAG]      = st.flag;
    csr_rd[`ACC_CSR_IEN]       = st.ctrl.ien;
    csr_rd[`ACC_CSR_CAPT]      = st.ctrl.capt;
    csr_rd[`ACC_CSR_MODE_HI:`ACC_CSR_MODE_LO] = st.ctrl.mode;
  end

  always_comb begin
    logic [7:0] nb;
    logic       clr_flag;
    logic       clr_ist;
    nb       = 8'h00;
    clr_flag = 1'b0;
    clr_ist  = 1'b0;
    next_st  = st;
    next_st.result_q = cmp_result;

    // Address and data may arrive in either order
    if (AWVALID && !st.aw_have) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr  = AWADDR;
    end
    if (WVALID && !st.w_have) begin
      next_st.w_have = 1'b1;
      next_st.wdata  = WDATA;
      next_st.wstrb  = WSTRB;
    end

    if (do_write) begin
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.wstate  = ACC_W_RESP;
      next_st.bresp   = `ACC_RESP_OKAY;
      case (st.awaddr)
        `ACC_OFF_CSR: begin
          nb = merge(csr_rd, wbyte, st.wstrb[0]);
          // Power-off takes effect whatever the block is doing
          next_st.ctrl.power_off = nb[`ACC_CSR_POWER_OFF];
          next_st.ctrl.bandgap   = nb[`ACC_CSR_BANDGAP];
          next_st.ctrl.ien       = nb[`ACC_CSR_IEN];
          next_st.ctrl.capt      = nb[`ACC_CSR_CAPT];
          next_st.ctrl.mode      =
            acc_mode_t'(nb[`ACC_CSR_MODE_HI:`ACC_CSR_MODE_LO]);
          clr_flag = st.wstrb[0] && wbyte[`ACC_CSR_FLAG];
        end
        `ACC_OFF_CSRB: begin
          if (st.wstrb[0]) begin
            next_st.mux_en = wbyte[`ACC_CSRB_MUX_EN];
          end
        end
        `ACC_OFF_ISTAT: begin
        end
        `ACC_OFF_IMASK: begin
          if (st.wstrb[0]) begin
            next_st.imask = wbyte[2:0];
          end
        end
        default: next_st.bresp = `ACC_RESP_SLVERR;
      endcase
    end
    if (st.wstate == ACC_W_RESP && BREADY) begin
      next_st.wstate = ACC_W_IDLE;
    end

    // Read path: one read in flight, data registered
    if (ARVALID && !st.rvalid) begin
      next_st.rvalid  = 1'b1;
      next_st.rd.addr = ARADDR;
      next_st.rresp   = `ACC_RESP_OKAY;
      case (ARADDR)
        `ACC_OFF_CSR:   next_st.rd.data = {24'h000000, csr_rd};
        `ACC_OFF_CSRB:  next_st.rd.data =
          {24'h000000, 1'b0, st.mux_en, 6'h00};
        `ACC_OFF_ISTAT: begin
          next_st.rd.data = {29'h00000000, st.istat};
          clr_ist = 1'b1;
        end
        `ACC_OFF_IMASK: next_st.rd.data = {29'h00000000, st.imask};
        default: begin
          next_st.rd.data = 32'h00000000;
          next_st.rresp   = `ACC_RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // Clears first so a same-cycle event wins
    if (clr_flag || IRQ_VECTOR_TAKEN) begin
      next_st.flag = 1'b0;
    end
    if (clr_ist) begin
      next_st.istat = 3'h0;
    end
    if (edge_hit) begin
      next_st.flag = 1'b1;
    end
    next_st.istat = next_st.istat |
      {fall, rise, edge_hit};
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st <= '0;
      st.ctrl <= acc_ctrl_t'(6'h00);
    end else begin
      st <= next_st;
    end
  end

  // Bus handshakes
  assign AWREADY = !st.aw_have;
  assign WREADY  = !st.w_have;
  assign BVALID  = st.wstate == ACC_W_RESP;
  assign BRESP   = st.bresp;
  assign ARREADY = !st.rvalid;
  assign RVALID  = st.rvalid;
  assign RDATA   = st.rd.data;
  assign RRESP   = st.rresp;

  // Analog steering; the mux path needs the converter idle
  assign CMP_POWER_OFF       = st.ctrl.power_off;
  assign CMP_POS_USE_BANDGAP = st.ctrl.bandgap;
  assign CMP_NEG_USE_MUX     = st.mux_en & ~conv_en;
  assign CAPTURE_TRIGGER     = st.ctrl.capt & cmp_result;
  assign CMP_IRQ = st.flag & st.ctrl.ien & gie;
  assign IRQ     = |(st.istat & st.imask);

  // Flag follows an edge one cycle later, in the selected mode
  rise_flag_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.ctrl.mode == ACC_MODE_RISE && rise |=> st.flag)
    else $error("rising edge did not set flag");
  reserved_mode_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.ctrl.mode == ACC_MODE_RESERVED |-> !edge_hit)
    else $error("reserved mode raised an event");
  edge_pulse_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    rise |=> !rise)
    else $error("edge event longer than one cycle");
  irq_gate_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    CMP_IRQ |-> st.ctrl.ien && GLOBAL_IRQ_ENABLE)
    else $error("interrupt without enables");
  neg_select_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    !st.mux_en || CONVERTER_ENABLE |-> !CMP_NEG_USE_MUX)
    else $error("mux used while not allowed");
  sync_delay_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    $rose(CMP_RAW) ##1 CMP_RAW |=> cmp_result)
    else $error("result lags raw output too long");
  capt_route_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    CAPTURE_TRIGGER |-> st.ctrl.capt && cmp_result)
    else $error("capture trigger without enable");
  power_write_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    do_write && st.awaddr == `ACC_OFF_CSR && st.wstrb[0]
      |=> CMP_POWER_OFF == $past(wbyte[`ACC_CSR_POWER_OFF]))
    else $error("power-off write not applied");
  toggle_flag_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.ctrl.mode == ACC_MODE_TOGGLE && (rise || fall) |=> st.flag)
    else $error("toggle did not set flag");
  fall_flag_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.ctrl.mode == ACC_MODE_FALL && fall |=> st.flag)
    else $error("falling edge did not set flag");
  // A read clear in the same cycle must not swallow the event
  istat_event_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    edge_hit |=> st.istat[`ACC_IST_EDGE])
    else $error("event lost from status");
  vector_clear_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    IRQ_VECTOR_TAKEN && !edge_hit |=> !st.flag)
    else $error("vector taken did not clear flag");
  irq_request_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.flag && st.ctrl.ien && GLOBAL_IRQ_ENABLE |-> CMP_IRQ)
    else $error("enabled flag gave no request");
  mux_select_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    st.mux_en && !CONVERTER_ENABLE |-> CMP_NEG_USE_MUX)
    else $error("mux not used while allowed");
  bandgap_write_a: assert property (
    @(posedge CLOCK) disable iff (RST)
    do_write && st.awaddr == `ACC_OFF_CSR && st.wstrb[0]
      |=> CMP_POS_USE_BANDGAP == $past(wbyte[`ACC_CSR_BANDGAP]))
    else $error("bandgap select write not applied");
endmodule

// [verification/acc_cmp_model.sv]
// Behavioural analog comparator standing behind the control block.
// Assumes bench-driven millivolt levels; the output follows at once.
module acc_cmp_model #(
  parameter int BANDGAP_MV = 50
) (
  // Analog levels
  input  wire logic [15:0] pos_mv,
  input  wire logic [15:0] neg_mv,
  input  wire logic [15:0] mux_mv,
  // Selection from the block
  input  wire logic        power_off,
  input  wire logic        use_bandgap,
  input  wire logic        neg_use_mux,
  // Raw decision
  output logic             raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] p;
  logic [15:0] n;
  always_comb begin
    p = use_bandgap ? 16'(BANDGAP_MV) : pos_mv;
    n = neg_use_mux ? mux_mv : neg_mv;
    // An unpowered comparator gives a quiet low output
    raw = !power_off && (p > n);
  end
endmodule

// [verification/tb_analog_comparator_control.sv]
// Self-checking bench for the comparator control block.
// Assumes acc_map.svh on the include path and the comparator model.
`include "acc_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_analog_comparator_control
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK = 0;
  logic        RST = 1;
  logic [3:0]  AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA, rd;
  logic [1:0]  BRESP, RRESP, rsp, m;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, CMP_RAW, CMP_IRQ, IRQ;
  logic        CONVERTER_ENABLE, CMP_POWER_OFF, CMP_POS_USE_BANDGAP;
  logic        CMP_NEG_USE_MUX, GLOBAL_IRQ_ENABLE, IRQ_VECTOR_TAKEN;
  logic        CAPTURE_TRIGGER, bg, mx, ce, er;
  logic [15:0] pos_mv, neg_mv, mux_mv;
  int          bad_count, tests_run, cycles, p, n, x;
  acc_mode_t   modes [4] = '{ACC_MODE_TOGGLE, ACC_MODE_FALL, ACC_MODE_RISE,
    ACC_MODE_RESERVED};

  always #5 CLOCK = ~CLOCK;

  acc_top u_dut (.CLOCK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .CMP_RAW,
    .CONVERTER_ENABLE, .CMP_POWER_OFF, .CMP_POS_USE_BANDGAP,
    .CMP_NEG_USE_MUX, .GLOBAL_IRQ_ENABLE, .IRQ_VECTOR_TAKEN, .CMP_IRQ,
    .CAPTURE_TRIGGER, .IRQ);
  acc_cmp_model u_cmp (.pos_mv, .neg_mv, .mux_mv,
    .power_off(CMP_POWER_OFF), .use_bandgap(CMP_POS_USE_BANDGAP),
    .neg_use_mux(CMP_NEG_USE_MUX), .raw(CMP_RAW));

  task automatic summarize();
    $display("tests %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Each request is held until the rising edge at which its ready is
  // seen high; the answer is taken at the edge that shows it valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic hb;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      hb = BVALID;
      rsp = BRESP;
    end
    BREADY <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    logic hr;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      hr = RVALID;
      rd = RDATA;
      rsp = RRESP;
    end
    RREADY <= 1'b0;
  endtask

  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    {AWADDR, ARADDR, WDATA, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    WSTRB = 4'h1;
    {CONVERTER_ENABLE, IRQ_VECTOR_TAKEN, pos_mv, mux_mv} = '0;
    GLOBAL_IRQ_ENABLE = 1'b1;
    neg_mv = 16'd500;
    void'($urandom(32'h3355e9a5));
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    rdr(`ACC_OFF_CSR);
    `CHK(rd, 32'h0)
    rdr(`ACC_OFF_CSRB);
    `CHK(rd, 32'h0)
    rdr(4'h2);
    `CHK({rsp, rd}, {`ACC_RESP_SLVERR, 32'h0})
    wr(4'h2, 8'h00);
    `CHK(rsp, `ACC_RESP_SLVERR)
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      {bg, mx, ce} = 3'($urandom);
      p = $urandom_range(99);
      n = $urandom_range(99);
      x = $urandom_range(99);
      pos_mv <= 16'(p);
      neg_mv <= 16'(n);
      mux_mv <= 16'(x);
      CONVERTER_ENABLE <= ce;
      wr(`ACC_OFF_CSR, {1'b0, bg, 6'h0});
      wr(`ACC_OFF_CSRB, {1'b0, mx, 6'h0});
      repeat (3) @(posedge CLOCK);
      // Selection changes toggle the result; clear the flag they left
      wr(`ACC_OFF_CSR, {1'b0, bg, 6'h10});
      rdr(`ACC_OFF_CSR);
      p = bg ? 50 : p;
      n = (mx && !ce) ? x : n;
      `CHK(rd[7:0], {1'b0, bg, p > n, 5'h0})
      `CHK(CMP_POS_USE_BANDGAP, bg)
      `CHK(CMP_NEG_USE_MUX, mx & !ce)
    end
    wr(`ACC_OFF_CSR, 8'h00);
    wr(`ACC_OFF_CSRB, 8'h00);
    pos_mv <= 16'd0;
    neg_mv <= 16'd500;
    $display("selection test done");
    wr(`ACC_OFF_IMASK, 8'h02);
    foreach (modes[i]) begin
      m = modes[i];
      rdr(`ACC_OFF_ISTAT);
      wr(`ACC_OFF_CSR, {6'h06, m});
      pos_mv <= 16'd900;
      repeat (6) @(posedge CLOCK);
      rdr(`ACC_OFF_CSR);
      er = (m == 2'h0 || m == 2'h3);
      `CHK(rd[7:0], {3'b001, er, 2'b10, m})
      @(negedge CLOCK);
      `CHK(CMP_IRQ, er)
      `CHK(IRQ, 1'b1)
      wr(`ACC_OFF_CSR, {6'h06, m});
      @(negedge CLOCK);
      `CHK(CMP_IRQ, 1'b0)
      @(posedge CLOCK);
      pos_mv <= 16'd0;
      repeat (6) @(posedge CLOCK);
      rdr(`ACC_OFF_CSR);
      er = (m == 2'h0 || m == 2'h2);
      `CHK(rd[7:0], {3'b000, er, 2'b10, m})
      rdr(`ACC_OFF_ISTAT);
      `CHK(rd, {29'h0, 2'b11, m != 2'h1})
      @(negedge CLOCK);
      `CHK(IRQ, 1'b0)
    end
    $display("mode test done");
    wr(`ACC_OFF_CSR, 8'h18);
    pos_mv <= 16'd900;
    repeat (6) @(posedge CLOCK);
    GLOBAL_IRQ_ENABLE <= 1'b0;
    @(negedge CLOCK);
    `CHK(CMP_IRQ, 1'b0)
    @(posedge CLOCK);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    @(negedge CLOCK);
    `CHK(CMP_IRQ, 1'b1)
    @(posedge CLOCK);
    IRQ_VECTOR_TAKEN <= 1'b1;
    @(posedge CLOCK);
    IRQ_VECTOR_TAKEN <= 1'b0;
    @(negedge CLOCK);
    `CHK(CMP_IRQ, 1'b0)
    // Interrupt enable is dropped before power-down, as software must
    wr(`ACC_OFF_CSR, 8'h00);
    wr(`ACC_OFF_CSR, 8'h80);
    `CHK(rsp, `ACC_RESP_OKAY)
    @(negedge CLOCK);
    `CHK(CMP_POWER_OFF, 1'b1)
    repeat (3) @(posedge CLOCK);
    rdr(`ACC_OFF_CSR);
    `CHK(rd[7:0], 8'h90)
    `CHK(CMP_IRQ, 1'b0)
    $display("power test done");
    wr(`ACC_OFF_CSR, 8'h14);
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    `CHK(CAPTURE_TRIGGER, 1'b1)
    @(posedge CLOCK);
    pos_mv <= 16'd0;
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    `CHK(CAPTURE_TRIGGER, 1'b0)
    $display("capture test done");
    summarize();
  end
endmodule
